// ==== logic/startup_interface_setup.sv ====
// Purpose: serial command interface of the converter with its start-up setup
// Assumes: pins asynchronous to REF_CLK_I, sclk well below a quarter of 250 MHz
// Notes: data sampled on sclk rise, serial_data_out shifts on sclk fall
`timescale 1ns/10ps
`include "serial_setup_params.svh"

module startup_interface_setup
(
   input wire logic REF_CLK_I,
   input wire logic ARST_N_I,
   input wire logic SCLK_I,
   input wire logic CS_N_I,
   input wire logic SDI_I,
   input wire logic [15:0] CONV_DATA_I,
   output logic SERIAL_DATA_OUT_O,
   output logic SERIAL_DATA_OUT_OE_O,
   output logic CHECK_ENABLE_O,
   output logic DATA_OUT_DISABLE_O,
   output logic CONVERTER_BUFFER_POWERDOWN_O,
   output logic FRAME_DROP_O
);

   // ************************************************************
   // check byte over the three command bytes
   // ************************************************************
   function automatic logic [7:0] check_byte(input logic [23:0] cmd);
      logic [7:0] crc;
      crc = `CHECK_INIT;
      for (int i = 23; i >= 0; i--)
      begin
         if (crc[7] ^ cmd[i])
         begin
            crc = {crc[6:0], 1'b0} ^ `CHECK_POLY;
         end
         else
         begin
            crc = {crc[6:0], 1'b0};
         end
      end
      return crc;
   endfunction

   // ************************************************************
   // pin synchronisers
   // ************************************************************
   logic [2:0] sclk_ff;
   logic [2:0] cs_n_ff;
   logic [1:0] sdi_ff;
   logic sclk_rise;
   logic sclk_fall;
   logic cs_start;
   logic cs_end;

   always_ff @(posedge REF_CLK_I or negedge ARST_N_I)
   begin
      if (!ARST_N_I)
      begin
         sclk_ff <= 3'h0;
         cs_n_ff <= 3'h7;
         sdi_ff <= 2'h0;
      end
      else
      begin
         sclk_ff <= {sclk_ff[1:0], SCLK_I};
         cs_n_ff <= {cs_n_ff[1:0], CS_N_I};
         sdi_ff <= {sdi_ff[0], SDI_I};
      end
   end

   // edges use stages two and three only, the first stage may be metastable
   assign sclk_rise = sclk_ff[1] & ~sclk_ff[2] & ~cs_n_ff[1];
   assign sclk_fall = ~sclk_ff[1] & sclk_ff[2] & ~cs_n_ff[1];
   assign cs_start = ~cs_n_ff[1] & cs_n_ff[2];
   assign cs_end = cs_n_ff[1] & ~cs_n_ff[2];

   // ************************************************************
   // frame capture, register writes and read return
   // ************************************************************
   serial_setup_pkg::frame_t shift_ff, nxt_shift;
   serial_setup_pkg::bit_count_t count_ff, nxt_count;
   serial_setup_pkg::reg_word_t cfg_ff, nxt_cfg;
   serial_setup_pkg::reg_word_t conv_cfg_ff, nxt_conv_cfg;
   serial_setup_pkg::reg_word_t read_ff, nxt_read;
   logic [23:0] out_ff, nxt_out;
   logic dout_ff, nxt_dout;
   logic oe_ff, nxt_oe;
   logic drop_ff, nxt_drop;
   logic [23:0] cmd;
   logic accept;
   logic checked;

   always_comb
   begin
      nxt_shift = shift_ff;
      nxt_count = count_ff;
      nxt_cfg = cfg_ff;
      nxt_conv_cfg = conv_cfg_ff;
      nxt_read = read_ff;
      nxt_out = out_ff;
      nxt_dout = dout_ff;
      nxt_drop = 1'b0;
      checked = cfg_ff[`CFG_CHECK_EN_BIT];
      cmd = checked ? shift_ff[31:8] : shift_ff[23:0];
      accept = 1'b0;
      if (cs_start)
      begin
         nxt_count = 6'h00;
         nxt_out = {8'h00, read_ff};
         nxt_dout = 1'b0;
      end
      if (sclk_rise)
      begin
         nxt_shift = {shift_ff[30:0], sdi_ff[1]};
         if (count_ff != 6'h3F)
         begin
            nxt_count = count_ff + 6'h01;
         end
      end
      if (sclk_fall)
      begin
         nxt_dout = out_ff[23];
         nxt_out = {out_ff[22:0], 1'b0};
      end
      if (cs_end)
      begin
         if (checked)
         begin
            accept = (count_ff == `CHECKED_BITS) && (check_byte(cmd) == shift_ff[7:0]);
         end
         else
         begin
            accept = (count_ff == `CMD_BITS);
         end
         nxt_drop = ~accept;
         nxt_dout = 1'b0;
      end
      if (accept)
      begin
         if (cmd[`READ_FLAG_BIT + 16])
         begin
            // read data goes out on serial_data_out during the next frame
            if (cmd[22:16] == `CFG_ADDR)
            begin
               nxt_read = cfg_ff;
            end
            else if (cmd[22:16] == `CONV_CFG_ADDR)
            begin
               nxt_read = conv_cfg_ff;
            end
            else if (cmd[22:16] == `CONV_DATA_ADDR)
            begin
               nxt_read = CONV_DATA_I;
            end
            else
            begin
               nxt_read = 16'h0000;
            end
         end
         else if (cmd[22:16] == `CFG_ADDR)
         begin
            nxt_cfg = cmd[15:0];
         end
         else if (cmd[22:16] == `CONV_CFG_ADDR)
         begin
            nxt_conv_cfg = cmd[15:0];
         end
      end
      // driven only inside a frame and only once the disable bit is clear
      nxt_oe = ~cs_n_ff[1] & ~cfg_ff[`CFG_DATA_OUT_DISABLE_BIT];
   end

   always_ff @(posedge REF_CLK_I or negedge ARST_N_I)
   begin
      if (!ARST_N_I)
      begin
         shift_ff <= 32'h00000000;
         count_ff <= 6'h00;
         cfg_ff <= `CFG_RESET;
         conv_cfg_ff <= `CONV_CFG_RESET;
         read_ff <= 16'h0000;
         out_ff <= 24'h000000;
         dout_ff <= 1'b0;
         oe_ff <= 1'b0;
         drop_ff <= 1'b0;
      end
      else
      begin
         shift_ff <= nxt_shift;
         count_ff <= nxt_count;
         cfg_ff <= nxt_cfg;
         conv_cfg_ff <= nxt_conv_cfg;
         read_ff <= nxt_read;
         out_ff <= nxt_out;
         dout_ff <= nxt_dout;
         oe_ff <= nxt_oe;
         drop_ff <= nxt_drop;
      end
   end

   assign SERIAL_DATA_OUT_O = dout_ff;
   assign SERIAL_DATA_OUT_OE_O = oe_ff;
   assign CHECK_ENABLE_O = cfg_ff[`CFG_CHECK_EN_BIT];
   assign DATA_OUT_DISABLE_O = cfg_ff[`CFG_DATA_OUT_DISABLE_BIT];
   assign CONVERTER_BUFFER_POWERDOWN_O = conv_cfg_ff[`CONV_BUFFER_POWERDOWN_BIT];
   assign FRAME_DROP_O = drop_ff;

endmodule

// ==== logic/serial_setup_params.svh ====
// Purpose: constants of the serial setup interface
// Assumes: 7-bit command address, 16-bit register data
// Notes: included by its bare name
`ifndef SERIAL_SETUP_PARAMS_SVH
`define SERIAL_SETUP_PARAMS_SVH

// ************************************************************
// register map
// ************************************************************
`define CFG_ADDR 7'h02
`define CONV_CFG_ADDR 7'h03
`define CONV_DATA_ADDR 7'h04
`define CFG_RESET 16'h0009
`define CONV_CFG_RESET 16'h0001
`define CFG_CHECK_EN_BIT 0
`define CFG_DATA_OUT_DISABLE_BIT 3
`define CONV_BUFFER_POWERDOWN_BIT 0
`define READ_FLAG_BIT 7

// ************************************************************
// frame format
// ************************************************************
`define CMD_BITS 6'h18
`define CHECKED_BITS 6'h20
`define CHECK_POLY 8'h07
`define CHECK_INIT 8'h00

`endif

// ==== logic/serial_setup_pkg.sv ====
// Purpose: shared types of the serial setup interface
// Assumes: nothing
// Notes: constants live in serial_setup_params.svh
package serial_setup_pkg;
   typedef logic [15:0] reg_word_t;
   typedef logic [31:0] frame_t;
   typedef logic [5:0] bit_count_t;
endpackage

// ==== test/startup_setup_checker.sv ====
// Purpose: port checks of the serial setup block
// Assumes: CS_N_I high for 6 cycles means no frame
// Notes: bound at the foot
`timescale 1ns/10ps
module startup_setup_checker
(
   input wire logic REF_CLK_I,
   input wire logic ARST_N_I,
   input wire logic CS_N_I,
   input wire logic SERIAL_DATA_OUT_O,
   input wire logic SERIAL_DATA_OUT_OE_O,
   input wire logic CHECK_ENABLE_O,
   input wire logic DATA_OUT_DISABLE_O,
   input wire logic CONVERTER_BUFFER_POWERDOWN_O,
   input wire logic FRAME_DROP_O
);
   default clocking cb @(posedge REF_CLK_I); endclocking
   default disable iff (!ARST_N_I);
   // six cycles covers the pin synchroniser plus the output register
   sequence cs_idle;
      CS_N_I [*6];
   endsequence
   a_reset_state: assert property ($rose(ARST_N_I) |-> CHECK_ENABLE_O &&
      DATA_OUT_DISABLE_O && CONVERTER_BUFFER_POWERDOWN_O && !SERIAL_DATA_OUT_OE_O)
      else $error("reset state");
   a_oe_needs_enable: assert property (SERIAL_DATA_OUT_OE_O |-> !DATA_OUT_DISABLE_O)
      else $error("oe while disabled");
   a_oe_idle: assert property (cs_idle |-> !SERIAL_DATA_OUT_OE_O)
      else $error("oe outside frame");
   a_data_idle: assert property (cs_idle |-> !SERIAL_DATA_OUT_O)
      else $error("data outside frame");
   a_cfg_at_end: assert property ($changed(CHECK_ENABLE_O) |-> $past(CS_N_I, 2))
      else $error("check bit moved in frame");
   a_drop_pulse: assert property (FRAME_DROP_O |=> !FRAME_DROP_O) else $error("long drop");
   a_drop_keeps: assert property (FRAME_DROP_O |-> $stable(CHECK_ENABLE_O) &&
      $stable(DATA_OUT_DISABLE_O) && $stable(CONVERTER_BUFFER_POWERDOWN_O)) else $error("drop wrote");
   a_drop_at_end: assert property (FRAME_DROP_O |-> CS_N_I && $past(CS_N_I, 2))
      else $error("drop inside frame");
endmodule
bind startup_interface_setup startup_setup_checker i_startup_setup_checker (.REF_CLK_I,
   .ARST_N_I, .CS_N_I, .SERIAL_DATA_OUT_O, .SERIAL_DATA_OUT_OE_O, .CHECK_ENABLE_O,
   .DATA_OUT_DISABLE_O, .CONVERTER_BUFFER_POWERDOWN_O, .FRAME_DROP_O);

// ==== test/serial_host.sv ====
// Purpose: host model bit-banging command frames
// Assumes: sclk high for 5 clock cycles and low for 6
// Notes: rx holds the 24 bits read during the last frame
`timescale 1ns/10ps
module serial_host
(
   input wire logic clk_i,
   input wire logic dout_i,
   input wire logic dout_oe_i,
   output logic sclk_o,
   output logic cs_n_o,
   output logic sdi_o
);
   logic [31:0] rx;
   // an undriven line shows the inverse, so a read with the output off fails
   wire logic line = dout_oe_i ? dout_i : ~dout_i;
   initial
   begin
      sclk_o = 1'b0;
      cs_n_o = 1'b1;
      sdi_o = 1'b0;
   end
   task automatic xfer(input logic [31:0] f, input int n);
      rx = 32'h0;
      @(posedge clk_i) cs_n_o <= 1'b0;
      for (int i = n - 1; i >= 0; i--)
      begin
         @(posedge clk_i) sdi_o <= f[i];
         repeat (5) @(posedge clk_i);
         sclk_o <= 1'b1;
         rx = {rx[30:0], line};
         repeat (5) @(posedge clk_i);
         sclk_o <= 1'b0;
      end
      // last bit leaves on the final fall, so take it just before deselect
      repeat (5) @(posedge clk_i);
      rx = {rx[30:0], line};
      cs_n_o <= 1'b1;
      sdi_o <= ~sdi_o;
      repeat (12) @(posedge clk_i);
   endtask
endmodule

// ==== test/test_startup_interface_setup.sv ====
// Purpose: start-up setup scenarios over the serial link
// Assumes: converter result held constant
// Notes: frames are driven by the host model
`timescale 1ns/10ps
module test_startup_interface_setup;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic sclk, cs_n, sdi, dout, oe, chk, dod, bpd, drop;
   logic [15:0] conv = 16'hA5C3;
   int fails = 0;
   int tests_run = 0;
   int drops = 0;
   always #2 clk = ~clk;
   always @(posedge clk) if (drop === 1'b1) drops++;
   startup_interface_setup i_startup_interface_setup (.REF_CLK_I(clk), .ARST_N_I(arst_n),
      .SCLK_I(sclk), .CS_N_I(cs_n), .SDI_I(sdi), .CONV_DATA_I(conv),
      .SERIAL_DATA_OUT_O(dout), .SERIAL_DATA_OUT_OE_O(oe), .CHECK_ENABLE_O(chk),
      .DATA_OUT_DISABLE_O(dod), .CONVERTER_BUFFER_POWERDOWN_O(bpd), .FRAME_DROP_O(drop));
   serial_host i_serial_host (.clk_i(clk), .dout_i(dout), .dout_oe_i(oe), .sclk_o(sclk),
      .cs_n_o(cs_n), .sdi_o(sdi));
   task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic do_reset;
      arst_n <= 1'b0;
      repeat (20) @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);
      check("cfg bits", 24'({chk, dod, bpd, oe}), 24'hE);
   endtask
   task automatic t_refused;
      i_serial_host.xfer(32'h02002625, 32);
      i_serial_host.xfer(32'h00020026, 24);
      check("drops", 24'(drops), 24'h2);
      check("check_en", 24'({chk, dod}), 24'h3);
   endtask
   task automatic t_setup;
      i_serial_host.xfer(32'h02002624, 32);
      check("cfg bits", 24'({chk, dod}), 24'h0);
      i_serial_host.xfer(32'h00030000, 24);
      check("converter_buffer_powerdown", 24'({bpd, drops[1:0]}), 24'h2);
   endtask
   task automatic t_read;
      i_serial_host.xfer(32'h00820000, 24);
      i_serial_host.xfer(32'h00840000, 24);
      check("cfg read", i_serial_host.rx[23:0], 24'h000026);
      i_serial_host.xfer(32'h00850000, 24);
      check("conv read", i_serial_host.rx[23:0], {8'h00, conv});
      i_serial_host.xfer(32'h00000000, 24);
      check("unmapped read", i_serial_host.rx[23:0], 24'h0);
   endtask
   task automatic t_rearm;
      i_serial_host.xfer(32'h00020000, 24);
      check("rearm drops", 24'(drops), 24'h3);
      check("rearm bits", 24'({chk, dod}), 24'h3);
   endtask
   initial
   begin
      do_reset;
      t_refused;
      t_setup;
      t_read;
      do_reset;
      t_rearm;
      summarize;
   end
   // whole run is near 11 us; a stuck frame loop ends here
   initial
   begin
      #100000;
      fails++;
      summarize;
   end
endmodule
